// ### design/startup_cfg_pkg.sv
// Constants, register map and types for the startup configuration block
// =====================================================================
package startup_cfg_pkg;

  // =====================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_MOTION_ERR = 8'h04;
  localparam logic [7:0] OFS_CONTROL    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

  // =====================================================================
  // Field positions
  localparam int CFG_DEFAULTS_BIT = 8;
  localparam int CFG_HW_SRC_BIT   = 9;
  localparam int DFLT_FLAG_BIT    = 2;
  localparam int CTL_ALIAS_BIT    = 0;
  localparam int CTL_ERR_OUT_BIT  = 1;
  localparam int IRQ_READY_BIT    = 0;
  localparam int IRQ_ERROR_BIT    = 1;
  localparam int IRQ_FSM_BIT      = 2;
  localparam int IRQ_W            = 3;

  // =====================================================================
  // Reset values and AXI response codes
  localparam logic [1:0]   CONTROL_RST   = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  localparam logic [1:0]   AXI_OKAY      = 2'h0;
  localparam logic [1:0]   AXI_SLVERR    = 2'h2;

  // =====================================================================
  // Indicator timing: one pattern step, a 24-step frame
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned STEP_MS    = 50;
  localparam int unsigned STEP_CYC   = CLK_HZ / 1000 * STEP_MS;
  localparam logic [4:0]  FRAME_LAST = 5'h17;
  localparam logic [4:0]  HALF_FRAME = 5'h0C;

  // Fieldbus slave state
  typedef enum logic [1:0] {FB_INIT, FB_PREOP, FB_SAFEOP, FB_OP} fb_state_t;
  // Error indication pattern
  typedef enum logic [2:0] {ERR_OFF, ERR_FLICKER, ERR_BLINK, ERR_SINGLE, ERR_DOUBLE, ERR_ON} err_ind_t;
  // Startup sequence
  typedef enum logic [1:0] {ST_SAMPLE, ST_DECIDE, ST_RUN} start_t;

endpackage

// ### design/startup_axis_id_config.sv
// Power-up configuration loader, node axis number and indicator drive
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module startup_axis_id_config #(
  parameter int unsigned STEP_CYCLES = startup_cfg_pkg::STEP_CYC,
  parameter int          HALL_W      = 3
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [HALL_W-1:0]           hall_in,
  input  wire logic [7:0]                  id_switch_bank,
  input  wire logic                        stored_table_valid,
  input  wire logic                        stored_axis_from_hw,
  input  wire logic [7:0]                  stored_axis_number,
  input  wire logic                        init_complete,
  input  wire logic                        fault_detected,
  input  wire logic                        error_output_pin,
  input  wire logic                        fieldbus_in_port_link,
  input  wire logic                        fieldbus_in_port_act,
  input  wire logic                        fieldbus_out_port_link,
  input  wire logic                        fieldbus_out_port_act,
  input  wire startup_cfg_pkg::fb_state_t  fb_state,
  input  wire startup_cfg_pkg::err_ind_t   fb_err_ind,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             use_defaults,
  output logic [7:0]                       node_axis_number,
  output logic [7:0]                       station_alias,
  output logic                             led_ready,
  output logic                             led_error,
  output logic                             led_fb_in,
  output logic                             led_fb_out,
  output logic                             led_status_green,
  output logic                             led_status_red,
  output logic                             irq
);
  import startup_cfg_pkg::*;

  // =====================================================================
  // Startup sequence state
  start_t     st_q, st_d;
  logic       hall_low_q, hall_low_d;
  logic [7:0] sw_q, sw_d;
  logic       dflt_q, dflt_d;
  logic       hw_src_q, hw_src_d;
  logic [7:0] axis_q, axis_d;

  // Next values of the startup sequence
  always_comb begin
    st_d       = st_q;
    hall_low_d = hall_low_q;
    sw_d       = sw_q;
    dflt_d     = dflt_q;
    hw_src_d   = hw_src_q;
    axis_d     = axis_q;
    case (st_q)
      ST_SAMPLE: begin
        hall_low_d = ~|hall_in;
        sw_d       = id_switch_bank;
        st_d       = ST_DECIDE;
      end
      ST_DECIDE: begin
        dflt_d   = hall_low_q | ~stored_table_valid;
        hw_src_d = hall_low_q | ~stored_table_valid | stored_axis_from_hw;
        // switch source when halls low, hardware or invalid
        if (hall_low_q | ~stored_table_valid | stored_axis_from_hw) begin
          axis_d = {1'b0, sw_q[7:1]};
        end else begin
          axis_d = stored_axis_number;
        end
        st_d = ST_RUN;
      end
      ST_RUN:  st_d = ST_RUN;
      default: st_d = ST_SAMPLE;
    endcase
  end

  // Reset equals power-up, so sampling restarts only on reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q       <= ST_SAMPLE;
      hall_low_q <= 1'b0;
      sw_q       <= 8'h00;
      dflt_q     <= 1'b0;
      hw_src_q   <= 1'b0;
      axis_q     <= 8'h00;
    end else begin
      st_q       <= st_d;
      hall_low_q <= hall_low_d;
      sw_q       <= sw_d;
      dflt_q     <= dflt_d;
      hw_src_q   <= hw_src_d;
      axis_q     <= axis_d;
    end
  end

  // =====================================================================
  // Pattern timebase: step enable and 24-step frame
  logic [31:0] div_q, div_d;
  logic [4:0]  ph_q, ph_d;
  logic        step_en;
  logic [4:0]  ph_run;

  always_comb begin
    step_en = (div_q == STEP_CYCLES - 1);
    div_d   = step_en ? 32'h0000_0000 : div_q + 32'h0000_0001;
    ph_d    = ph_q;
    if (step_en) begin
      ph_d = (ph_q == FRAME_LAST) ? 5'h00 : ph_q + 5'h01;
    end
    // Run shown half a frame away from error
    ph_run = (ph_q >= HALF_FRAME) ? ph_q - HALF_FRAME : ph_q + HALF_FRAME;
  end

  // Frame counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q <= 32'h0000_0000;
      ph_q  <= 5'h00;
    end else begin
      div_q <= div_d;
      ph_q  <= ph_d;
    end
  end

  // Blink 200 ms halves, flicker 50 ms, flashes 200 ms on
  function automatic logic pat_on(input logic [2:0] kind, input logic [4:0] ph);
    case (kind)
      ERR_FLICKER: pat_on = ph[0];
      ERR_BLINK:   pat_on = ~ph[2];
      ERR_SINGLE:  pat_on = (ph < 5'h04);
      ERR_DOUBLE:  pat_on = (ph < 5'h04) || (ph >= 5'h08 && ph < 5'h0C);
      ERR_ON:      pat_on = 1'b1;
      default:     pat_on = 1'b0;
    endcase
  endfunction

  // =====================================================================
  // Register and indicator state
  logic [1:0]       ctl_q, ctl_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic             err_now, err_q, ready_now, ready_q, fbst_chg;
  fb_state_t        fbst_q;
  logic             act_in_q, act_in_d, act_out_q, act_out_d;
  logic             run_on, err_on;
  logic [6:0]       leds_d, leds_q;

  // Activity seen during the current step shows as flicker
  always_comb begin
    act_in_d  = step_en ? fieldbus_in_port_act : (act_in_q | fieldbus_in_port_act);
    act_out_d = step_en ? fieldbus_out_port_act : (act_out_q | fieldbus_out_port_act);
    err_now   = fault_detected | error_output_pin | ctl_q[CTL_ERR_OUT_BIT];
    // ready only after init, no error
    ready_now = (st_q == ST_RUN) & init_complete & ~err_now;
    case (fbst_q)
      FB_PREOP:  run_on = pat_on(ERR_BLINK, ph_run);
      FB_SAFEOP: run_on = pat_on(ERR_SINGLE, ph_run);
      FB_OP:     run_on = 1'b1;
      default:   run_on = 1'b0;
    endcase
    err_on = pat_on(fb_err_ind, ph_q);
    leds_d[0] = ready_now;
    leds_d[1] = err_now;
    leds_d[2] = fieldbus_in_port_link & ~(act_in_q & ph_q[0]);
    leds_d[3] = fieldbus_out_port_link & ~(act_out_q & ph_q[0]);
    leds_d[4] = run_on & ~err_on;
    leds_d[5] = err_on;
    fbst_chg  = (fb_state != fbst_q);
    leds_d[6] = |(ist_q & ien_q);
  end

  // Indicator registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act_in_q  <= 1'b0;
      act_out_q <= 1'b0;
      err_q     <= 1'b0;
      ready_q   <= 1'b0;
      fbst_q    <= FB_INIT;
      leds_q    <= 7'h00;
    end else begin
      act_in_q  <= act_in_d;
      act_out_q <= act_out_d;
      err_q     <= err_now;
      ready_q   <= ready_now;
      fbst_q    <= fb_state;
      leds_q    <= leds_d;
    end
  end

  // =====================================================================
  // AXI4-Lite slave: address and data taken in either order
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic        bv_q, bv_d, rv_q, rv_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic        do_wr, do_rd, ar_rdy;

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awa_d     = awa_q;
    wd_d      = wd_q;
    ws_d      = ws_q;
    bv_d      = bv_q;
    br_d      = br_q;
    rv_d      = rv_q;
    rr_d      = rr_q;
    rd_d      = rd_q;
    ctl_d     = ctl_q;
    ien_d     = ien_q;
    ist_d     = ist_q;
    // Taken only on a real handshake; ready is still low just after reset
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awa_d     = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wd_d     = s_axi_wdata;
      ws_d     = s_axi_wstrb;
    end
    do_wr = aw_hold_q && w_hold_q && !bv_q;
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bv_d      = 1'b1;
      br_d      = AXI_OKAY;
      case (awa_q)
        OFS_CONTROL:    if (ws_q[0]) ctl_d = wd_q[1:0];
        OFS_IRQ_ENABLE: if (ws_q[0]) ien_d = wd_q[IRQ_W-1:0];
        OFS_IRQ_CLEAR:  if (ws_q[0]) ist_d = ist_q & ~wd_q[IRQ_W-1:0];
        OFS_CONFIG, OFS_MOTION_ERR, OFS_IRQ_STATUS: br_d = AXI_OKAY;
        default:        br_d = AXI_SLVERR;
      endcase
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    // Events set after the clear so a same-cycle event survives
    if (st_q == ST_RUN && !ready_q && ready_now) ist_d[IRQ_READY_BIT] = 1'b1;
    if (err_now && !err_q) ist_d[IRQ_ERROR_BIT] = 1'b1;
    if (fbst_chg) ist_d[IRQ_FSM_BIT] = 1'b1;
    ar_rdy = s_axi_arready;
    do_rd  = s_axi_arvalid && ar_rdy;
    if (do_rd) begin
      rv_d = 1'b1;
      rr_d = AXI_OKAY;
      rd_d = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CONFIG: begin
          rd_d[7:0]              = axis_q;
          rd_d[CFG_DEFAULTS_BIT] = dflt_q;
          rd_d[CFG_HW_SRC_BIT]   = hw_src_q;
        end
        OFS_MOTION_ERR: rd_d[DFLT_FLAG_BIT] = dflt_q;
        OFS_CONTROL:    rd_d[1:0] = ctl_q;
        OFS_IRQ_STATUS: rd_d[IRQ_W-1:0] = ist_q;
        OFS_IRQ_ENABLE: rd_d[IRQ_W-1:0] = ien_q;
        OFS_IRQ_CLEAR:  rd_d = 32'h0000_0000;
        default:        rr_d = AXI_SLVERR;
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  // Bus and register flip-flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awa_q     <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      bv_q      <= 1'b0;
      br_q      <= AXI_OKAY;
      rv_q      <= 1'b0;
      rr_q      <= AXI_OKAY;
      rd_q      <= 32'h0000_0000;
      ctl_q     <= CONTROL_RST;
      ien_q     <= IRQ_EN_RST;
      ist_q     <= 3'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awa_q     <= awa_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      bv_q      <= bv_d;
      br_q      <= br_d;
      rv_q      <= rv_d;
      rr_q      <= rr_d;
      rd_q      <= rd_d;
      ctl_q     <= ctl_d;
      ien_q     <= ien_d;
      ist_q     <= ist_d;
    end
  end

  // Ready flags are registered; each holds high until its item is taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_d && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_d && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !rv_d && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // =====================================================================
  // Outputs straight from flip-flops
  always_comb begin
    s_axi_bvalid     = bv_q;
    s_axi_bresp      = br_q;
    s_axi_rvalid     = rv_q;
    s_axi_rresp      = rr_q;
    s_axi_rdata      = rd_q;
    use_defaults     = dflt_q;
    node_axis_number = axis_q;
    led_ready        = leds_q[0];
    led_error        = leds_q[1];
    led_fb_in        = leds_q[2];
    led_fb_out       = leds_q[3];
    led_status_green = leds_q[4];
    led_status_red   = leds_q[5];
    irq              = leds_q[6];
  end

  // alias follows axis number in node-address mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      station_alias <= 8'h00;
    end else begin
      station_alias <= ctl_q[CTL_ALIAS_BIT] ? axis_q : 8'h00;
    end
  end

endmodule

// ### tb/startup_cfg_props.sv
// Port-level checks of the startup configuration block
`timescale 1ns/1ps
module startup_cfg_props #(
  parameter int unsigned STEP_CYCLES = 4,
  parameter int          HALL_W      = 3
) (
  input wire logic                       mclk,
  input wire logic                       rst_n,
  input wire logic [HALL_W-1:0]          hall_in,
  input wire logic                       init_complete,
  input wire logic                       fault_detected,
  input wire logic                       error_output_pin,
  input wire logic                       fieldbus_in_port_link,
  input wire startup_cfg_pkg::fb_state_t fb_state,
  input wire startup_cfg_pkg::err_ind_t  fb_err_ind,
  input wire logic                       use_defaults,
  input wire logic [7:0]                 node_axis_number,
  input wire logic [7:0]                 station_alias,
  input wire logic                       led_ready,
  input wire logic                       led_error,
  input wire logic                       led_fb_in,
  input wire logic                       led_status_green,
  input wire logic                       led_status_red
);
  import startup_cfg_pkg::*;
  logic [1:0] up_q;
  logic [1:0] up_d;
  // Cycles since release, saturating so the startup steps are over at 3
  always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge mclk) begin
    if (!rst_n) up_q <= 2'h0;
    else up_q <= up_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_fault;
    fault_detected || error_output_pin;
  endsequence
  sequence s_settle;
    ##[1:3] use_defaults;
  endsequence
  a_hall_defaults: assert property ($rose(rst_n) && hall_in == '0 |-> s_settle)
    else $error("defaults not taken with halls low");
  a_axis_bit7: assert property (use_defaults |-> !node_axis_number[7])
    else $error("switch number has bit 7 set");
  a_axis_frozen: assert property (up_q == 2'h3 |=> $stable(node_axis_number) && $stable(use_defaults))
    else $error("axis number moved after startup");
  a_alias_match: assert property (station_alias != 8'h00 |-> station_alias == node_axis_number)
    else $error("alias differs from axis number");
  a_error_lit: assert property (s_fault |=> led_error)
    else $error("error light missing");
  a_ready_dark: assert property (s_fault |=> !led_ready)
    else $error("ready light on during error");
  a_ready_init: assert property (!init_complete |=> !led_ready)
    else $error("ready light before init");
  a_red_wins: assert property (led_status_red |-> !led_status_green)
    else $error("status shows both colours");
  a_port_dark: assert property (!fieldbus_in_port_link |=> !led_fb_in)
    else $error("port light without link");
  // init is dark, state is registered before it shows
  a_init_dark: assert property ($past(fb_state) == FB_INIT |=> !led_status_green)
    else $error("run light in init");
  a_op_steady: assert property ($past(fb_state) == FB_OP && fb_err_ind == ERR_OFF |=> led_status_green)
    else $error("run light off in operational");
  a_err_steady: assert property (fb_err_ind == ERR_ON |=> led_status_red)
    else $error("status not red on error");
endmodule

bind startup_axis_id_config startup_cfg_props #(.STEP_CYCLES(STEP_CYCLES), .HALL_W(HALL_W)) u_props (
  .mclk(mclk), .rst_n(rst_n), .hall_in(hall_in), .init_complete(init_complete),
  .fault_detected(fault_detected), .error_output_pin(error_output_pin),
  .fieldbus_in_port_link(fieldbus_in_port_link), .fb_state(fb_state), .fb_err_ind(fb_err_ind),
  .use_defaults(use_defaults), .node_axis_number(node_axis_number), .station_alias(station_alias),
  .led_ready(led_ready), .led_error(led_error), .led_fb_in(led_fb_in),
  .led_status_green(led_status_green), .led_status_red(led_status_red)
);

// ### tb/fb_master_model.sv
// Fieldbus master stand-in: walks the slave state, drives link lines
`timescale 1ns/1ps
module fb_master_model (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire startup_cfg_pkg::fb_state_t goal,
  input  wire startup_cfg_pkg::err_ind_t  err_req,
  input  wire logic                       link_up,
  input  wire logic                       act_en,
  output startup_cfg_pkg::fb_state_t      fb_state,
  output startup_cfg_pkg::err_ind_t       fb_err_ind,
  output logic                            link,
  output logic                            act
);
  import startup_cfg_pkg::*;
  fb_state_t st_d;
  fb_state_t st_q;
  // One state step a cycle, never skipping a state
  always_comb begin
    st_d = st_q;
    if (goal > st_q) st_d = fb_state_t'(st_q + 2'h1);
    else if (goal < st_q) st_d = fb_state_t'(st_q - 2'h1);
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) st_q <= FB_INIT;
    else st_q <= st_d;
  end
  // Indications and link follow the bench's requests
  assign fb_state   = st_q;
  assign fb_err_ind = err_req;
  assign link       = link_up;
  assign act        = act_en;
endmodule

// ### tb/startup_axis_id_config_tb_top.sv
// Self-checking bench for the startup configuration block
`timescale 1ns/1ps
module startup_axis_id_config_tb_top;
  import startup_cfg_pkg::*;
  // =====================================================================
  // Signals
  localparam int unsigned STEP = 4;
  logic mclk = 1'b0, rst_n = 1'b0, vld = 1'b1, fromhw = 1'b0, init_c = 1'b0, fault = 1'b0, epin = 1'b0;
  logic [2:0] hall = 3'h7;
  logic [7:0] sw = 8'h00, ax = 8'h01, awaddr = 8'h00, araddr = 8'h00, nax, alias_v;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dflt, l_rdy, l_err, l_in, l_out, l_g, l_r, irq;
  logic link_up = 1'b0, act_en = 1'b0, link, act;
  logic [1:0] bresp, rresp;
  fb_state_t goal = FB_INIT, fbs;
  err_ind_t err_req = ERR_OFF, fbe;
  int n_errors = 0, checks_done = 0, cyc = 0;
  int run_on[4] = '{0, 12 * STEP, 4 * STEP, 24 * STEP};
  int port_on[4] = '{0, 48 * STEP, 0, 24 * STEP};
  int err_on[6] = '{0, 12 * STEP, 12 * STEP, 4 * STEP, 8 * STEP, 24 * STEP};

  startup_axis_id_config #(.STEP_CYCLES(STEP), .HALL_W(3)) u_startup_axis_id_config (
    .mclk(mclk), .rst_n(rst_n), .hall_in(hall), .id_switch_bank(sw), .stored_table_valid(vld),
    .stored_axis_from_hw(fromhw), .stored_axis_number(ax), .init_complete(init_c),
    .fault_detected(fault), .error_output_pin(epin), .fieldbus_in_port_link(link),
    .fieldbus_in_port_act(act), .fieldbus_out_port_link(link), .fieldbus_out_port_act(act),
    .fb_state(fbs), .fb_err_ind(fbe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .use_defaults(dflt),
    .node_axis_number(nax), .station_alias(alias_v), .led_ready(l_rdy), .led_error(l_err),
    .led_fb_in(l_in), .led_fb_out(l_out), .led_status_green(l_g), .led_status_red(l_r), .irq(irq));
  fb_master_model u_fb_master_model (
    .mclk(mclk), .rst_n(rst_n), .goal(goal), .err_req(err_req), .link_up(link_up), .act_en(act_en),
    .fb_state(fbs), .fb_err_ind(fbe), .link(link), .act(act));

  // =====================================================================
  // Clock and hang guard, well under two thousand cycles are expected
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      conclude();
    end
  end

  // =====================================================================
  // Tasks
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  // No wait limit here: only the hang guard ends a stuck transfer
  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk(rresp, er);
  endtask
  // Power-up with the given halls, switches and stored setup
  task automatic boot(input logic [2:0] h, input logic [7:0] s, input logic v, input logic hw, input logic [7:0] a);
    @(posedge mclk);
    rst_n <= 1'b0;
    hall <= h;
    sw <= s;
    vld <= v;
    fromhw <= hw;
    ax <= a;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // Lit cycles over one indicator frame
  task automatic frame(output int g, output int r, output int p);
    g = 0;
    r = 0;
    p = 0;
    repeat (24 * STEP) begin
      @(posedge mclk);
      g += l_g;
      r += l_r;
      p += l_in + l_out;
    end
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    int g, r, p;
    boot(3'h0, 8'hA5, 1'b1, 1'b0, 8'hC8);
    chk(dflt, 1'b1);
    chk(nax, 8'h52);
    rdchk(OFS_CONFIG, 32'h0000_0352, AXI_OKAY);
    rdchk(OFS_MOTION_ERR, 32'h0000_0004, AXI_OKAY);
    boot(3'h5, 8'h01, 1'b0, 1'b0, 8'hC8);
    rdchk(OFS_CONFIG, 32'h0000_0300, AXI_OKAY);
    boot(3'h5, 8'h10, 1'b1, 1'b0, 8'hFF);
    sw <= 8'hFE;
    hall <= 3'h0;
    repeat (5) @(posedge mclk);
    rdchk(OFS_CONFIG, 32'h0000_00FF, AXI_OKAY);
    rdchk(OFS_MOTION_ERR, 32'h0, AXI_OKAY);
    boot(3'h5, 8'hFE, 1'b1, 1'b1, 8'h05);
    rdchk(OFS_CONFIG, 32'h0000_027F, AXI_OKAY);
    rdchk(OFS_IRQ_ENABLE, 32'h0, AXI_OKAY);
    chk(l_rdy, 1'b0);
    init_c <= 1'b1;
    wrchk(OFS_CONTROL, 32'h1, AXI_OKAY);
    repeat (3) @(posedge mclk);
    chk({alias_v, l_rdy}, {8'h7F, 1'b1});
    rdchk(OFS_CONTROL, 32'h1, AXI_OKAY);
    wrchk(OFS_MOTION_ERR, 32'hFFFF_FFFF, AXI_OKAY);
    rdchk(8'h40, 32'h0, AXI_SLVERR);
    // Each error source in turn
    for (int i = 0; i < 3; i++) begin
      fault <= (i == 0);
      epin <= (i == 1);
      if (i == 2) wrchk(OFS_CONTROL, 32'h3, AXI_OKAY);
      repeat (3) @(posedge mclk);
      chk({l_rdy, l_err}, 2'b01);
      fault <= 1'b0;
      epin <= 1'b0;
      if (i == 2) wrchk(OFS_CONTROL, 32'h1, AXI_OKAY);
      repeat (3) @(posedge mclk);
      chk({l_rdy, l_err}, 2'b10);
    end
    // Interrupt raised, cleared, then masked
    wrchk(OFS_IRQ_CLEAR, 32'h7, AXI_OKAY);
    wrchk(OFS_IRQ_ENABLE, 32'h2, AXI_OKAY);
    fault <= 1'b1;
    repeat (3) @(posedge mclk);
    fault <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    rdchk(OFS_IRQ_STATUS, 32'h3, AXI_OKAY);
    rdchk(OFS_IRQ_CLEAR, 32'h0, AXI_OKAY);
    wrchk(OFS_IRQ_CLEAR, 32'h2, AXI_OKAY);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    wrchk(OFS_IRQ_ENABLE, 32'h1, AXI_OKAY);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    wrchk(OFS_IRQ_ENABLE, 32'h0, AXI_OKAY);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    // Run pattern for every state, with link and activity mixes
    for (int s = 0; s < 4; s++) begin
      goal <= fb_state_t'(s);
      link_up <= s[0];
      act_en <= s[1];
      repeat (8) @(posedge mclk);
      frame(g, r, p);
      chk(g, run_on[s]);
      chk(p, port_on[s]);
    end
    // State walk adds the fieldbus change bit to the earlier ready bit
    rdchk(OFS_IRQ_STATUS, 32'h5, AXI_OKAY);
    // Every error pattern over steady green, red taking precedence
    for (int e = 0; e < 6; e++) begin
      err_req <= err_ind_t'(e);
      repeat (8) @(posedge mclk);
      frame(g, r, p);
      chk(r, err_on[e]);
      chk(g, 24 * STEP - err_on[e]);
    end
    conclude();
  end
endmodule
